//--- common/adc_seq_pkg.sv
/*
  Shared constants and types for the converter channel sequencer:
  register offsets, control field positions, reset values and the
  sequencing mode enumeration.
  Assumes a 32-bit APB register bus with byte addresses.
*/
package adc_seq_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register map (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;    // control word
  localparam logic [7:0] OFS_SHADOW = 8'h04;  // channel enable mask
  localparam logic [7:0] OFS_STATUS = 8'h08;  // sequencer state, read only

  ////////////////////////////////////////////////////////////////////////
  // control register field positions
  localparam int CTRL_ADDR_LSB = 0;    // channel_address, 3 bits
  localparam int CTRL_SEQ_BIT = 3;     // sequence_select
  localparam int CTRL_SHADOW_ENABLE_BIT = 4;    // shadow_enable
  localparam int CTRL_CFG_LSB = 5;     // input_config_lo, then _hi
  localparam int CTRL_REF_BIT = 7;     // reference source

  // status register field positions
  localparam int STAT_NEXT_LSB = 0;    // channel of next conversion
  localparam int STAT_CUR_LSB = 3;     // channel of last conversion
  localparam int STAT_MODE_LSB = 6;    // running mode
  localparam int STAT_COUNT_LSB = 16;  // conversions started

  ////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] SHADOW_RESET = 8'h00;

  // input configuration codes {input_config_hi, input_config_lo}
  localparam logic [1:0] CFG_SINGLE8 = 2'h0;
  localparam logic [1:0] CFG_PSEUDO4 = 2'h1;
  localparam logic [1:0] CFG_DIFF4 = 2'h2;
  localparam logic [1:0] CFG_PSEUDO7 = 2'h3;

  // channel used as common return in seven-input pseudo mode
  localparam logic [2:0] PSEUDO_COMMON_INPUT = 3'h7;

  ////////////////////////////////////////////////////////////////////////
  // sequencing behaviour
  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_PROG,
    MODE_CONSEC
  } mode_t;

endpackage

//--- src/pin_fall_detect.sv
/*
  Three-flop synchroniser with agreement filter and falling edge pulse
  for an asynchronous pin.
  Assumes one system clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps

module pin_fall_detect (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin_in,
  output logic fall
);

  ////////////////////////////////////////////////////////////////////////
  // all state in one struct
  typedef struct packed {
    logic s1;     // first flop, read only by s2
    logic s2;     // second flop
    logic s3;     // third flop
    logic level;  // accepted pin level
    logic fall;   // one-cycle falling pulse
  } sync_t;

  sync_t st_q;
  sync_t st_d;

  // next state: level changes only when s2 and s3 agree
  always_comb begin
    st_d = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.fall = 1'b0;
    if (st_q.s2 == st_q.s3) begin
      st_d.level = st_q.s3;
      st_d.fall = st_q.level & ~st_q.s3;
    end
  end

  // register, idle pin level is high
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, level: 1'b1, fall: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign fall = st_q.fall;

endmodule

//--- src/adc_channel_sequencer.sv
/*
  Channel selection and sequencing control for an eight-input converter,
  with control and shadow registers on an APB slave.
  Assumes a 25 MHz system clock, synchronous active-high reset and a
  convert-start pin asynchronous to the clock.
*/
`timescale 1ns/1ps

module adc_channel_sequencer (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CONVERT_START_N,
  output logic CONV_START,
  output logic [2:0] POS_CHANNEL,
  output logic [2:0] NEG_CHANNEL,
  output logic NEG_IS_GROUND,
  output logic [1:0] INPUT_CONFIG,
  output logic REF_EXTERNAL
);

  ////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [2:0] addr;           // channel_address
    logic [1:0] cfg;            // input configuration
    logic ref_ext;              // reference source
    logic [7:0] shadow;         // channel enable mask
    adc_seq_pkg::mode_t mode;   // running behaviour
    logic [2:0] next;           // channel for next conversion
    logic [2:0] cur;            // channel of last conversion
    logic [2:0] pos;            // positive mux input
    logic [2:0] neg;            // negative mux input
    logic gnd;                  // negative side is ground
    logic conv;                 // conversion start pulse
    logic ack;                  // apb ready
    logic err;                  // apb error
    logic [31:0] rdata;         // apb read data
    logic [15:0] count;         // conversions started
  } state_t;

  state_t st_q;
  state_t st_d;
  logic fall;                   // synchronised convert-start fall
  logic access;                 // apb access phase
  logic wr_ctrl;                // control write takes effect
  logic wr_shadow;              // shadow write takes effect
  logic [1:0] wseq;             // written {sequence_select, shadow_enable}

  ////////////////////////////////////////////////////////////////////////
  // first enabled channel at or after a start, wrapping; 0 if none
  function automatic logic [2:0] first_enabled(input logic [7:0] mask,
                                               input logic [2:0] from);
    logic [2:0] idx;
    logic [2:0] res;
    logic found;
    res = 3'h0;
    found = 1'b0;
    for (int i = 0; i < 8; i++) begin
      idx = from + 3'(i);
      if (!found && mask[idx]) begin
        res = idx;
        found = 1'b1;
      end
    end
    return res;
  endfunction

  // mux inputs {pos, neg, gnd} for a channel under a configuration
  function automatic logic [6:0] mux_inputs(input logic [1:0] cfg,
                                            input logic [2:0] ch);
    logic [6:0] res;
    unique case (cfg)
      adc_seq_pkg::CFG_SINGLE8: begin
        res = {ch, 3'h0, 1'b1};
      end
      adc_seq_pkg::CFG_DIFF4, adc_seq_pkg::CFG_PSEUDO4: begin
        res = {ch[1:0], 1'b0, ch[1:0], 1'b1, 1'b0};
      end
      adc_seq_pkg::CFG_PSEUDO7: begin
        res = {ch, adc_seq_pkg::PSEUDO_COMMON_INPUT, 1'b0};
      end
    endcase
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // convert-start pin synchroniser
  pin_fall_detect u_fall (
    .clk(CLK_SYS),
    .rst(RST),
    .pin_in(CONVERT_START_N),
    .fall(fall)
  );

  // apb decode; a write lands on the edge where pready is seen high
  assign access = PSEL & PENABLE;
  assign wr_ctrl = access & st_q.ack & PWRITE
                   & (PADDR == adc_seq_pkg::OFS_CTRL);
  assign wr_shadow = access & st_q.ack & PWRITE
                     & (PADDR == adc_seq_pkg::OFS_SHADOW);
  assign wseq = {PWDATA[adc_seq_pkg::CTRL_SEQ_BIT],
                 PWDATA[adc_seq_pkg::CTRL_SHADOW_ENABLE_BIT]};

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_d = st_q;
    st_d.conv = 1'b0;
    // apb: one wait state, then ready with data and error
    st_d.ack = access & ~st_q.ack;
    if (access && !st_q.ack) begin
      st_d.err = 1'b0;
      st_d.rdata = 32'h0000_0000;
      unique case (PADDR)
        adc_seq_pkg::OFS_CTRL: begin
          st_d.rdata[adc_seq_pkg::CTRL_ADDR_LSB +: 3] = st_q.addr;
          st_d.rdata[adc_seq_pkg::CTRL_SEQ_BIT] =
            (st_q.mode == adc_seq_pkg::MODE_CONSEC);
          st_d.rdata[adc_seq_pkg::CTRL_SHADOW_ENABLE_BIT] =
            (st_q.mode != adc_seq_pkg::MODE_SINGLE);
          st_d.rdata[adc_seq_pkg::CTRL_CFG_LSB +: 2] = st_q.cfg;
          st_d.rdata[adc_seq_pkg::CTRL_REF_BIT] = st_q.ref_ext;
        end
        adc_seq_pkg::OFS_SHADOW: begin
          st_d.rdata[7:0] = st_q.shadow;
        end
        adc_seq_pkg::OFS_STATUS: begin
          st_d.rdata[adc_seq_pkg::STAT_NEXT_LSB +: 3] = st_q.next;
          st_d.rdata[adc_seq_pkg::STAT_CUR_LSB +: 3] = st_q.cur;
          st_d.rdata[adc_seq_pkg::STAT_MODE_LSB +: 2] = st_q.mode;
          st_d.rdata[adc_seq_pkg::STAT_COUNT_LSB +: 16] = st_q.count;
        end
        default: begin
          // unmapped address: error, no effect
          st_d.err = 1'b1;
        end
      endcase
    end
    // conversion start: select channel; advance the pointer in programmable and consecutive modes
    if (fall) begin
      st_d.conv = 1'b1;
      st_d.count = st_q.count + 16'h0001;
      unique case (st_q.mode)
        adc_seq_pkg::MODE_SINGLE: begin
          st_d.cur = st_q.addr;
        end
        adc_seq_pkg::MODE_PROG: begin
          st_d.cur = st_q.next;
          st_d.next = first_enabled(st_q.shadow,
                                    st_q.next + 3'h1);
        end
        adc_seq_pkg::MODE_CONSEC: begin
          st_d.cur = st_q.next;
          st_d.next = (st_q.next >= st_q.addr) ? 3'h0
                      : st_q.next + 3'h1;
        end
        default: begin
          st_d.cur = st_q.addr;
        end
      endcase
      {st_d.pos, st_d.neg, st_d.gnd} = mux_inputs(st_q.cfg, st_d.cur);
    end
    // shadow write reloads the start of a programmable sequence
    if (wr_shadow) begin
      st_d.shadow = PWDATA[7:0];
      if (st_q.mode == adc_seq_pkg::MODE_PROG) begin
        st_d.next = first_enabled(PWDATA[7:0], 3'h0);
      end
    end
    // control write; a write with pattern 01 or 11 replaces a same-cycle advance of next
    if (wr_ctrl) begin
      st_d.cfg = PWDATA[adc_seq_pkg::CTRL_CFG_LSB +: 2];
      st_d.ref_ext = PWDATA[adc_seq_pkg::CTRL_REF_BIT];
      unique case (wseq)
        2'b10: begin
          // continue pattern: sequence left untouched
          st_d.mode = st_q.mode;
        end
        2'b00: begin
          st_d.mode = adc_seq_pkg::MODE_SINGLE;
          st_d.addr = PWDATA[adc_seq_pkg::CTRL_ADDR_LSB +: 3];
        end
        2'b01: begin
          st_d.mode = adc_seq_pkg::MODE_PROG;
          st_d.addr = PWDATA[adc_seq_pkg::CTRL_ADDR_LSB +: 3];
          st_d.next = first_enabled(st_d.shadow, 3'h0);
        end
        2'b11: begin
          st_d.mode = adc_seq_pkg::MODE_CONSEC;
          st_d.addr = PWDATA[adc_seq_pkg::CTRL_ADDR_LSB +: 3];
          st_d.next = 3'h0;
        end
      endcase
    end
  end

  // register with synchronous reset
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      st_q <= '{addr: adc_seq_pkg::CTRL_RESET[2:0],
                cfg: adc_seq_pkg::CTRL_RESET[6:5],
                ref_ext: adc_seq_pkg::CTRL_RESET[7],
                shadow: adc_seq_pkg::SHADOW_RESET,
                mode: adc_seq_pkg::MODE_SINGLE,
                gnd: 1'b1,
                rdata: 32'h0000_0000,
                count: 16'h0000,
                default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign PRDATA = st_q.rdata;
  assign PREADY = st_q.ack;
  assign PSLVERR = st_q.ack & st_q.err;
  assign CONV_START = st_q.conv;
  assign POS_CHANNEL = st_q.pos;
  assign NEG_CHANNEL = st_q.neg;
  assign NEG_IS_GROUND = st_q.gnd;
  assign INPUT_CONFIG = st_q.cfg;
  assign REF_EXTERNAL = st_q.ref_ext;

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_single_channel: assert property (@(posedge CLK_SYS) disable iff (RST)
    fall && !wr_ctrl && st_q.mode == adc_seq_pkg::MODE_SINGLE
    |=> st_q.cur == $past(st_q.addr) && CONV_START)
    else $error("single mode converted wrong channel");

  chk_prog_enabled: assert property (@(posedge CLK_SYS) disable iff (RST)
    fall && st_q.mode == adc_seq_pkg::MODE_PROG && st_q.shadow != 8'h00
    |=> st_q.shadow[st_q.cur])
    else $error("programmable sequence used a disabled channel");

  chk_prog_lowest: assert property (@(posedge CLK_SYS) disable iff (RST)
    (wr_ctrl && wseq == 2'b01
     || wr_shadow && st_q.mode == adc_seq_pkg::MODE_PROG)
    ##1 st_q.shadow != 8'h00
    |-> st_q.shadow[st_q.next]
        && ((st_q.shadow & ((8'h01 << st_q.next) - 8'h01)) == 8'h00))
    else $error("sequence did not start at lowest enabled channel");

  chk_prog_step: assert property (@(posedge CLK_SYS) disable iff (RST)
    fall && !wr_ctrl && !wr_shadow
    && st_q.mode == adc_seq_pkg::MODE_PROG && st_q.shadow != 8'h00
    |=> st_q.shadow[st_q.next] && st_q.cur == $past(st_q.next))
    else $error("programmable sequence stepped wrongly");

  chk_continue_keeps: assert property (@(posedge CLK_SYS) disable iff (RST)
    wr_ctrl && wseq == 2'b10 && !fall
    |=> $stable(st_q.mode) && $stable(st_q.next) && $stable(st_q.addr))
    else $error("continue write disturbed the sequence");

  chk_consec_rise: assert property (@(posedge CLK_SYS) disable iff (RST)
    fall && !wr_ctrl && st_q.mode == adc_seq_pkg::MODE_CONSEC
    && st_q.next < st_q.addr
    |=> st_q.next == $past(st_q.next) + 3'h1)
    else $error("consecutive sequence did not rise by one");

  chk_consec_wrap: assert property (@(posedge CLK_SYS) disable iff (RST)
    fall && !wr_ctrl && st_q.mode == adc_seq_pkg::MODE_CONSEC
    && st_q.next == st_q.addr
    |=> st_q.next == 3'h0 ##1 st_q.next == 3'h0 || fall)
    else $error("consecutive sequence did not wrap to 0");

  chk_ref_select: assert property (@(posedge CLK_SYS) disable iff (RST)
    wr_ctrl |=> REF_EXTERNAL == $past(PWDATA[adc_seq_pkg::CTRL_REF_BIT]))
    else $error("reference select not taken from write");

  chk_pseudo_common: assert property (@(posedge CLK_SYS) disable iff (RST)
    fall && st_q.cfg == adc_seq_pkg::CFG_PSEUDO7
    |=> NEG_CHANNEL == adc_seq_pkg::PSEUDO_COMMON_INPUT && !NEG_IS_GROUND)
    else $error("seven-input pseudo mode not referred to channel 7");

  chk_single_ended: assert property (@(posedge CLK_SYS) disable iff (RST)
    fall && st_q.cfg == adc_seq_pkg::CFG_SINGLE8
    |=> NEG_IS_GROUND && POS_CHANNEL == st_q.cur)
    else $error("single-ended mux setting wrong");

  chk_pair_mux: assert property (@(posedge CLK_SYS) disable iff (RST)
    fall && (st_q.cfg == adc_seq_pkg::CFG_PSEUDO4
             || st_q.cfg == adc_seq_pkg::CFG_DIFF4)
    |=> !NEG_IS_GROUND && POS_CHANNEL == {st_q.cur[1:0], 1'b0}
        && NEG_CHANNEL == POS_CHANNEL + 3'h1)
    else $error("pseudo pair mux setting wrong");

  chk_start_cause: assert property (@(posedge CLK_SYS) disable iff (RST)
    CONV_START |-> $past(fall) ##1 !CONV_START)
    else $error("conversion started without falling edge");

  chk_enter_consec: assert property (@(posedge CLK_SYS) disable iff (RST)
    wr_ctrl && wseq == 2'b11 |=> st_q.next == 3'h0)
    else $error("consecutive entry did not reset pointer");

endmodule

//--- tb/apb_host_model.sv
/*
  Host model: APB master and convert-start pin driver for the sequencer.
  Assumes one rising-edge clock shared with the design.
*/
`timescale 1ns/1ps

module apb_host_model (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic convert_start_n,
  input wire logic conv_start
);
  ////////////////////////////////////////////////////////////////////////
  // idle bus, pin parked high
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    convert_start_n = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // one apb transfer, held until pready is sampled high
  // writes happen only between conversions, never during one
  task automatic xfer(input logic wr, input logic [7:0] addr,
                      input logic [31:0] wdata, output logic [31:0] rdata,
                      output logic err);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready === 1'b1) begin
      // answer taken at the edge where pready is seen high
      rdata = prdata;
      err = pslverr;
    end else begin
      // no answer in time: flagged so the caller counts a mismatch
      rdata = 32'hFFFF_FFFF;
      err = 1'b1;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // falling edge on the pin, then wait for the start pulse
  task automatic convert(output logic seen);
    int n = 0;
    seen = 1'b0;
    @(posedge clk);
    convert_start_n <= 1'b0;
    // pulse stands one cycle, so look at every edge
    while (!seen && n < 10) begin
      @(posedge clk);
      n++;
      seen = (conv_start === 1'b1);
    end
    // release and keep high past the minimum spacing
    convert_start_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule

//--- tb/test_adc_channel_sequencer.sv
/*
  Self-checking bench for the channel sequencer: registers over APB,
  conversions started by the host model's pin.
  Assumes the shared package and the host model are compiled first.
*/
`timescale 1ns/1ps

module test_adc_channel_sequencer;
  logic clk_sys = 1'b0; // 25 MHz system clock
  logic rst = 1'b1; // synchronous reset
  wire psel, penable, pwrite, pready, pslverr; // apb controls
  wire [7:0] paddr; // apb address
  wire [31:0] pwdata, prdata; // apb data
  wire cs_n, conv_start, neg_gnd, ref_ext; // pin and flags
  wire [2:0] pos_ch, neg_ch; // mux selection
  wire [1:0] in_cfg; // input configuration
  int n_errors = 0; // mismatches seen
  int total_checks = 0; // comparisons made
  logic [31:0] rd; // last read data
  logic err; // last slave error
  logic seen; // start pulse observed

  always #20 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////
  // design and host
  adc_channel_sequencer u_adc_channel_sequencer (
    .CLK_SYS(clk_sys), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .CONVERT_START_N(cs_n),
    .CONV_START(conv_start), .POS_CHANNEL(pos_ch), .NEG_CHANNEL(neg_ch),
    .NEG_IS_GROUND(neg_gnd), .INPUT_CONFIG(in_cfg), .REF_EXTERNAL(ref_ext));

  apb_host_model u_apb_host_model (
    .clk(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .convert_start_n(cs_n), .conv_start(conv_start));

  ////////////////////////////////////////////////////////////////////////
  // comparison and bus helpers
  task automatic check(input string what, input logic [31:0] got,
                       input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_apb_host_model.xfer(1'b1, a, d, rd, err);
    check("write error", {31'h0, err}, 32'h0);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    u_apb_host_model.xfer(1'b0, a, 32'h0, rd, err);
    check("read error", {31'h0, err}, 32'h0);
    check("read data", rd, exp);
  endtask

  // one conversion, then the positive input it used
  task automatic conv(input logic [2:0] exp_pos);
    u_apb_host_model.convert(seen);
    check("start pulse", {31'h0, seen}, 32'h1);
    check("pos channel", {29'h0, pos_ch}, {29'h0, exp_pos});
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // expected mux per configuration, address 6, three bits per code
  localparam logic [11:0] CFG_POS = 12'hD26; // codes 3..0: 6 4 4 6
  localparam logic [11:0] CFG_NEG = 12'hF68; // codes 3..0: 7 5 5 0
  localparam logic [3:0] CFG_GND = 4'h1; // only single-ended grounds

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    // reset state
    check("gnd after reset", {31'h0, neg_gnd}, 32'h1);
    rdc(adc_seq_pkg::OFS_CTRL, 32'h0);
    rdc(adc_seq_pkg::OFS_SHADOW, 32'h0);
    $display("test reset done");
    // single channel, any order, reference select
    wr(adc_seq_pkg::OFS_CTRL, 32'h85);
    conv(3'h5);
    check("ref ext", {31'h0, ref_ext}, 32'h1);
    wr(adc_seq_pkg::OFS_CTRL, 32'h02);
    conv(3'h2);
    check("ref int", {31'h0, ref_ext}, 32'h0);
    $display("test single done");
    // every input configuration
    for (int c = 0; c < 4; c++) begin
      wr(adc_seq_pkg::OFS_CTRL, {24'h0, 1'b0, c[1:0], 5'h06});
      conv(CFG_POS[3*c +: 3]);
      check("config", {30'h0, in_cfg}, {30'h0, c[1:0]});
      check("gnd", {31'h0, neg_gnd}, {31'h0, CFG_GND[c]});
      if (!CFG_GND[c]) begin
        check("neg", {29'h0, neg_ch}, {29'h0, CFG_NEG[3*c +: 3]});
      end
    end
    $display("test config done");
    // programmable: channels 1, 4, 7 then wrap
    wr(adc_seq_pkg::OFS_SHADOW, 32'h92);
    wr(adc_seq_pkg::OFS_CTRL, 32'h10);
    conv(3'h1);
    conv(3'h4);
    conv(3'h7);
    conv(3'h1);
    wr(adc_seq_pkg::OFS_CTRL, 32'h08);
    conv(3'h4);
    wr(adc_seq_pkg::OFS_CTRL, 32'h10);
    conv(3'h1);
    wr(adc_seq_pkg::OFS_SHADOW, 32'h48);
    conv(3'h3);
    wr(adc_seq_pkg::OFS_CTRL, 32'h03);
    conv(3'h3);
    $display("test programmable done");
    // consecutive: 0 up to 2, then restart
    wr(adc_seq_pkg::OFS_CTRL, 32'h1A);
    conv(3'h0);
    conv(3'h1);
    conv(3'h2);
    conv(3'h0);
    rdc(adc_seq_pkg::OFS_STATUS, 32'h0012_0081);
    wr(adc_seq_pkg::OFS_CTRL, 32'h08);
    conv(3'h1);
    wr(adc_seq_pkg::OFS_CTRL, 32'h1A);
    conv(3'h0);
    rdc(adc_seq_pkg::OFS_CTRL, 32'h1A);
    $display("test consecutive done");
    // unmapped address and read-only status
    u_apb_host_model.xfer(1'b0, 8'h0C, 32'h0, rd, err);
    check("unmapped error", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    wr(adc_seq_pkg::OFS_STATUS, 32'hFF);
    rdc(adc_seq_pkg::OFS_STATUS, 32'h0014_0081);
    $display("test bus done");
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    $display("watchdog expired");
    tally_and_finish();
  end
endmodule
